// file: src/gd_ctrl_pkg.sv
// shared constants for the gate driver host controller
package gd_ctrl_pkg;
    // clock and pin timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int DEGLITCH_NS     = 40;
    localparam int DEGLITCH_CYC    = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
    // shortest pulse we emit: well clear of the device deglitch window
    localparam int PULSE_MIN_CYC   = 2 * DEGLITCH_CYC;
    // input filter length on the status pins
    localparam int PIN_FILT_CYC    = 4;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam logic [7:0] DUTY_OFS   = 8'h0C;
    localparam logic [7:0] MUTE_OFS   = 8'h10;
    localparam logic [7:0] FILTER_OFS = 8'h14;

    // control register fields
    localparam int CTRL_ENABLE     = 0;
    localparam int CTRL_AUTO_RST   = 1;
    localparam int CTRL_PWM_ON_NEG = 2;
    localparam int CTRL_RUN        = 3;
    localparam int CTRL_CLEAR      = 4;
    localparam int CTRL_AUTO_CLEAR = 5;
    localparam int CTRL_W          = 6;

    // status register fields
    localparam int ST_FAULT        = 0;
    localparam int ST_READY        = 1;
    localparam int ST_FAULT_SEEN   = 2;
    localparam int ST_BUSY         = 3;
    localparam int ST_W            = 4;

    localparam int CNT_W           = 16;
    localparam int TIME_W          = 24;

    localparam logic [CNT_W-1:0]  PERIOD_RST = 16'h04E2;
    localparam logic [CNT_W-1:0]  DUTY_RST   = 16'h0271;
    localparam logic [TIME_W-1:0] MUTE_RST   = 24'h0001F4;
    localparam logic [TIME_W-1:0] FILTER_RST = 24'h0000FA;

    typedef enum logic [1:0] {
        CLR_IDLE    = 2'b00,
        CLR_MUTE    = 2'b01,
        CLR_LOW     = 2'b10,
        CLR_RELEASE = 2'b11
    } clr_state_t;
endpackage : gd_ctrl_pkg

// file: src/pin_sync_filter.sv
// two-stage synchroniser followed by a stability filter for one pin
`timescale 1ns/100ps
module pin_sync_filter #(
    parameter int   STABLE_CYC = 4,
    parameter logic RST_VAL    = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    localparam logic [CW-1:0] CNT_END = CW'(STABLE_CYC - 1);

    logic          meta_r;
    logic          sync_r;
    logic [CW-1:0] cnt_r;

    if (STABLE_CYC < 1) begin : g_bad_stable
        $error("STABLE_CYC must be at least 1");
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    // a level must hold STABLE_CYC cycles; pull-up ringing is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r   <= '0;
            level_o <= RST_VAL;
        end else if (sync_r == level_o) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_END) begin
            cnt_r   <= '0;
            level_o <= sync_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : pin_sync_filter

// file: src/gd_host_ctrl.sv
// host-side controller: pwm, reset/enable and fault handling for the driver
//
// Contract
// - hold reset/enable high to enable outputs.
// - clear fault: hold low reset filter time.
// - auto reset: tie pwm to reset/enable.
// - auto reset on inverting input needs inversion.
// - pwm off time must exceed reset filter.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module gd_host_ctrl #(
    parameter int MUTE_DEF   = 500,
    parameter int FILTER_DEF = 250
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fault_alarm_n_i,
    input  wire logic        ready_i,
    output logic             pwm_pos_o,
    output logic             pwm_neg_o,
    output logic             rst_en_o
);
    import gd_ctrl_pkg::*;

    if (MUTE_DEF < 1 || MUTE_DEF >= (1 << TIME_W)) begin : g_bad_mute
        $error("MUTE_DEF out of range");
    end
    if (FILTER_DEF < 1 || FILTER_DEF >= (1 << TIME_W)) begin : g_bad_filter
        $error("FILTER_DEF out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // status pins

    logic fault_n_f;
    logic ready_f;

    // open-drain fault pin idles high, ready resets low; either level counts only once stable
    pin_sync_filter #(
        .STABLE_CYC (PIN_FILT_CYC),
        .RST_VAL    (1'b1)
    ) u_fault_pin (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (fault_alarm_n_i),
        .level_o (fault_n_f)
    );

    pin_sync_filter #(
        .STABLE_CYC (PIN_FILT_CYC),
        .RST_VAL    (1'b0)
    ) u_ready_pin (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (ready_i),
        .level_o (ready_f)
    );

    logic fault_act;
    assign fault_act = !fault_n_f;

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [CTRL_W-1:0] ctrl_r;
    logic [CNT_W-1:0]  period_r;
    logic [CNT_W-1:0]  duty_r;
    logic [TIME_W-1:0] mute_r;
    logic [TIME_W-1:0] filter_r;
    logic              fault_seen_r;
    logic              clear_pulse_r;
    clr_state_t        state_r;

    logic bus_req;
    logic wr_hit;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_hit  = bus_req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // only byte lane 0 and 1 carry the narrow fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= '0;
            period_r <= PERIOD_RST;
            duty_r   <= DUTY_RST;
            mute_r   <= TIME_W'(MUTE_DEF);
            filter_r <= TIME_W'(FILTER_DEF);
        end else if (wr_hit) begin
            case (wb_adr_i)
                CTRL_OFS: begin
                    if (wb_sel_i[0]) ctrl_r <= wb_dat_i[CTRL_W-1:0];
                end
                PERIOD_OFS: begin
                    if (wb_sel_i[0]) period_r[7:0]  <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) period_r[15:8] <= wb_dat_i[15:8];
                end
                DUTY_OFS: begin
                    if (wb_sel_i[0]) duty_r[7:0]  <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) duty_r[15:8] <= wb_dat_i[15:8];
                end
                MUTE_OFS: begin
                    if (wb_sel_i[0]) mute_r[7:0]   <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) mute_r[15:8]  <= wb_dat_i[15:8];
                    if (wb_sel_i[2]) mute_r[23:16] <= wb_dat_i[23:16];
                end
                FILTER_OFS: begin
                    if (wb_sel_i[0]) filter_r[7:0]   <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) filter_r[15:8]  <= wb_dat_i[15:8];
                    if (wb_sel_i[2]) filter_r[23:16] <= wb_dat_i[23:16];
                end
                default: begin
                end
            endcase
        end else begin
            // the clear command is self-clearing
            ctrl_r[CTRL_CLEAR] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_pulse_r <= 1'b0;
        end else begin
            clear_pulse_r <= wr_hit && wb_adr_i == CTRL_OFS && wb_sel_i[0]
                             && wb_dat_i[CTRL_CLEAR];
        end
    end

    // a new fault wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_seen_r <= 1'b0;
        end else if (fault_act) begin
            fault_seen_r <= 1'b1;
        end else if (wr_hit && wb_adr_i == STATUS_OFS && wb_sel_i[0]
                     && wb_dat_i[ST_FAULT_SEEN]) begin
            fault_seen_r <= 1'b0;
        end
    end

    logic [ST_W-1:0] status;
    assign status = {state_r != CLR_IDLE, fault_seen_r, ready_f, fault_act};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFS:   wb_dat_o <= 32'(ctrl_r);
                STATUS_OFS: wb_dat_o <= 32'(status);
                PERIOD_OFS: wb_dat_o <= 32'(period_r);
                DUTY_OFS:   wb_dat_o <= 32'(duty_r);
                MUTE_OFS:   wb_dat_o <= 32'(mute_r);
                FILTER_OFS: wb_dat_o <= 32'(filter_r);
                default:    wb_dat_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm generator

    logic             enable;
    logic             auto_rst;
    logic             on_neg;
    assign enable   = ctrl_r[CTRL_ENABLE];
    assign auto_rst = ctrl_r[CTRL_AUTO_RST];
    assign on_neg   = ctrl_r[CTRL_PWM_ON_NEG];

    logic [CNT_W-1:0] cnt_r;
    logic [TIME_W:0]  off_min;
    logic [TIME_W:0]  on_max;
    logic [CNT_W-1:0] duty_eff;

    // off time guard: filter plus pin latency margin in auto reset
    always_comb begin
        off_min = auto_rst
                  ? {1'b0, filter_r} + (TIME_W+1)'(PULSE_MIN_CYC)
                  : (TIME_W+1)'(PULSE_MIN_CYC);
        on_max  = (off_min >= (TIME_W+1)'(period_r)) ? '0
                  : (TIME_W+1)'(period_r) - off_min;
        duty_eff = duty_r;
        if ((TIME_W+1)'(duty_r) > on_max) begin
            duty_eff = on_max[CNT_W-1:0];
        end
        // a sliver the device would swallow is not sent at all
        if (duty_eff < CNT_W'(PULSE_MIN_CYC)) begin
            duty_eff = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_r[CTRL_RUN]) begin
            cnt_r <= '0;
        end else if (cnt_r >= period_r - 1'b1) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    logic phase;
    logic gate_ok;
    assign phase   = cnt_r < duty_eff;
    // no switching without supply; outside auto reset also none during a fault or while clearing
    assign gate_ok = enable && ctrl_r[CTRL_RUN] && ready_f
                     && (auto_rst || (!fault_act && state_r == CLR_IDLE));

    ////////////////////////////////////////////////////////////////////////
    // fault clear sequence

    logic [TIME_W-1:0] tmr_r;
    logic              start_clr;
    assign start_clr = fault_act && !auto_rst
                       && (clear_pulse_r || ctrl_r[CTRL_AUTO_CLEAR]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= CLR_IDLE;
            tmr_r   <= '0;
        end else begin
            case (state_r)
                CLR_IDLE: begin
                    tmr_r <= '0;
                    if (start_clr) state_r <= CLR_MUTE;
                end
                // the device ignores the pin until mute time ends
                CLR_MUTE: begin
                    if (tmr_r >= mute_r) begin
                        tmr_r   <= '0;
                        state_r <= CLR_LOW;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                // low for the whole filter time after mute
                CLR_LOW: begin
                    if (tmr_r >= filter_r) begin
                        tmr_r   <= '0;
                        state_r <= CLR_RELEASE;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                // alarm should let go once the pin is back high
                CLR_RELEASE: begin
                    if (!fault_act) begin
                        state_r <= CLR_IDLE;
                    end else if (tmr_r >= filter_r) begin
                        tmr_r   <= '0;
                        state_r <= CLR_MUTE;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= CLR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive

    logic pos_nxt;
    logic neg_nxt;
    logic rst_en_nxt;

    always_comb begin
        if (on_neg) begin
            // inverting use: positive input held high, pwm inverted
            pos_nxt = gate_ok;
            neg_nxt = gate_ok && !phase;
        end else begin
            pos_nxt = gate_ok && phase;
            neg_nxt = 1'b0;
        end
        if (!enable) begin
            rst_en_nxt = 1'b0;
        end else if (auto_rst) begin
            // reset rides the pwm; inverting use needs the inversion
            rst_en_nxt = on_neg ? !neg_nxt : pos_nxt;
        end else begin
            rst_en_nxt = (state_r == CLR_IDLE || state_r == CLR_RELEASE);
        end
    end

    // all three pins change on the same edge: no skew into the interlock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_pos_o <= 1'b0;
            pwm_neg_o <= 1'b0;
            rst_en_o  <= 1'b0;
        end else begin
            pwm_pos_o <= pos_nxt;
            pwm_neg_o <= neg_nxt;
            rst_en_o  <= rst_en_nxt;
        end
    end
endmodule : gd_host_ctrl

// file: tb/gd_host_ctrl_checker.sv
// port assertions for the gate driver host controller
`timescale 1ns/100ps
module gd_host_ctrl_checker
    import gd_ctrl_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        fault_alarm_n_i,
    input wire logic        ready_i,
    input wire logic        pwm_pos_o,
    input wire logic        pwm_neg_o,
    input wire logic        rst_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_req;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    ////////////////////////////////////////////////////////////////////////
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_ack_cause;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_hold;
        !wb_ack_o |-> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("data moved");
    property p_unmapped_zero;
        rd_req && wb_adr_i > FILTER_OFS |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped");
    property p_quiet_reset;
        disable iff (1'h0) rst_i |=> !wb_ack_o && !pwm_pos_o && !rst_en_o;
    endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("reset");
    // gate command is pos high with neg low, in either pwm mode
    property p_no_supply_gate_off;
        (!ready_i)[*8] ##1 !ready_i |=> !(pwm_pos_o && !pwm_neg_o);
    endproperty
    a_no_supply_gate_off: assert property (p_no_supply_gate_off)
        else $error("gate on without supply");
    property p_ready_bit;
        ready_i[*8] ##1 (ready_i && rd_req && wb_adr_i == STATUS_OFS)
            |=> wb_dat_o[ST_READY];
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("ready bit");
    property p_fault_bit;
        (!fault_alarm_n_i)[*8] ##1
            (!fault_alarm_n_i && rd_req && wb_adr_i == STATUS_OFS)
            |=> wb_dat_o[ST_FAULT];
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("fault bit");
    c_write: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);
    c_fault: cover property ($fell(fault_alarm_n_i));
    c_reset_pulse: cover property ($fell(rst_en_o));
endmodule : gd_host_ctrl_checker

bind gd_host_ctrl gd_host_ctrl_checker i_gd_host_ctrl_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fault_alarm_n_i(fault_alarm_n_i), .ready_i(ready_i),
    .pwm_pos_o(pwm_pos_o), .pwm_neg_o(pwm_neg_o), .rst_en_o(rst_en_o));

// file: tb/gd_device_model.sv
// behavioural model of the isolated gate driver's logic pins
`timescale 1ns/100ps
module gd_device_model #(
    parameter int MUTE_CYC = 8,
    parameter int FILT_CYC = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic in_pos_i,
    input  wire logic in_neg_i,
    input  wire logic rst_en_i,
    input  wire logic oc_trip_i,
    input  wire logic uv_i,
    output logic      fault_alarm_n_o,
    output logic      ready_o,
    output logic      gate_o
);
    logic fault_r;
    logic en;
    int   mute_r;
    int   low_r;
    import gd_ctrl_pkg::*;
    logic [2:0] raw;
    logic [2:0] flt_r;
    int         held_r [3];
    // undriven or unknown reads low through the pull-down
    assign raw = {rst_en_i === 1'h1, in_neg_i === 1'h1, in_pos_i === 1'h1};
    // a level passes only once it has stood DEGLITCH_CYC cycles
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            if (rst_i) begin
                held_r[k] <= 0;
                flt_r[k]  <= 1'h0;
            end else if (raw[k] == flt_r[k]) begin
                held_r[k] <= 0;
            end else if (held_r[k] >= DEGLITCH_CYC - 1) begin
                held_r[k] <= 0;
                flt_r[k]  <= raw[k];
            end else begin
                held_r[k] <= held_r[k] + 1;
            end
        end
    end
    assign en = flt_r[2];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_r <= 1'h0;
            mute_r  <= 0;
            low_r   <= 0;
        end else if (oc_trip_i && !fault_r) begin
            fault_r <= 1'h1;
            mute_r  <= MUTE_CYC;
            low_r   <= 0;
        end else if (mute_r != 0) begin
            mute_r <= mute_r - 1;
        end else if (en) begin
            low_r <= 0;
        end else if (low_r >= FILT_CYC) begin
            fault_r <= 1'h0;
        end else begin
            low_r <= low_r + 1;
        end
    end
    // not open drain: drives low on a fault and actively high otherwise
    assign fault_alarm_n_o = fault_r ? 1'h0 : 1'h1;
    assign ready_o = uv_i ? 1'h0 : 1'h1;
    // soft turn-off ramp not modelled, gate simply drops
    assign gate_o = en && !fault_r && !uv_i
                    && flt_r[0] && !flt_r[1];
endmodule : gd_device_model

// file: tb/testbench.sv
// self-checking bench for the gate driver host controller
`timescale 1ns/100ps
module testbench;
    import gd_ctrl_pkg::*;
    localparam int MUTE_C = 8;
    localparam int FILT_C = 4;
    localparam logic [31:0] ENR = (32'h1 << CTRL_ENABLE) | (32'h1 << CTRL_RUN);
    localparam logic [31:0] AUTO = 32'h1 << CTRL_AUTO_RST;
    localparam logic [31:0] NEGM = 32'h1 << CTRL_PWM_ON_NEG;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        cyc = 1'h0;
    logic        stb = 1'h0;
    logic        we = 1'h0;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic        oc = 1'h0;
    logic        uv = 1'h0;
    logic [31:0] rdat;
    logic        ack, pos, neg, rst_en, flt_n, rdy, gate;
    int          bad_count = 0;
    int          comparisons = 0;
    gd_host_ctrl #(.MUTE_DEF(MUTE_C), .FILTER_DEF(FILT_C)) i_gd_host_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .fault_alarm_n_i(flt_n),
        .ready_i(rdy), .pwm_pos_o(pos), .pwm_neg_o(neg), .rst_en_o(rst_en));
    gd_device_model #(.MUTE_CYC(MUTE_C), .FILT_CYC(FILT_C)) i_gd_device_model (
        .clk_i(clk_i), .rst_i(rst_i), .in_pos_i(pos), .in_neg_i(neg),
        .rst_en_i(rst_en), .oc_trip_i(oc), .uv_i(uv), .fault_alarm_n_o(flt_n),
        .ready_o(rdy), .gate_o(gate));
    initial forever #4 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    // entered just after a rising edge; returns one edge after the ack
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 50);
        check(n < 50, 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask : wr
    task automatic count(input int n, output int p, output int g);
        p = 0;
        g = 0;
        repeat (n) begin
            @(posedge clk_i);
            p += int'(pos === 1'h1);
            g += int'(gate === 1'h1);
        end
    endtask : count
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        bus(PERIOD_OFS, 1'h0, 32'h0, q); check(q, {16'h0, PERIOD_RST});
        bus(DUTY_OFS, 1'h0, 32'h0, q); check(q, {16'h0, DUTY_RST});
        bus(MUTE_OFS, 1'h0, 32'h0, q); check(q, MUTE_C);
        bus(FILTER_OFS, 1'h0, 32'h0, q); check(q, FILT_C);
        sel <= 4'h2;
        wr(PERIOD_OFS, 32'h0000AB00);
        sel <= 4'hF;
        bus(PERIOD_OFS, 1'h0, 32'h0, q);
        check(q, {16'h0, 8'hAB, PERIOD_RST[7:0]});
        wr(8'h40, 32'hFFFFFFFF);
        bus(8'h40, 1'h0, 32'h0, q); check(q, 32'h0);
        check(rst_en, 1'h0);
        wr(CTRL_OFS, 32'h1 << CTRL_ENABLE);
        repeat (4) @(posedge clk_i);
        check(rst_en, 1'h1);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[ST_READY], 1'h1);
    endtask : t_regs
    task automatic t_pwm();
        int p, g, d, i;
        int duty[3] = '{20, 35, 5};
        int want[3] = '{40, 60, 0};
        wr(PERIOD_OFS, 32'd40);
        wr(CTRL_OFS, ENR);
        for (i = 0; i < 3; i++) begin
            wr(DUTY_OFS, duty[i]);
            repeat (40) @(posedge clk_i);
            count(80, p, g);
            check(p, want[i]);
            check(g, want[i]);
        end
        wr(DUTY_OFS, 32'd20);
    endtask : t_pwm
    task automatic t_fault();
        logic [31:0] q;
        int p, g, n, lo;
        oc <= 1'h1;
        @(posedge clk_i);
        oc <= 1'h0;
        repeat (12) @(posedge clk_i);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[ST_FAULT], 1'h1);
        count(40, p, g);
        check(p + g, 0);
        wr(CTRL_OFS, ENR | (32'h1 << CTRL_CLEAR));
        n = 0;
        while (rst_en !== 1'h0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        lo = 0;
        while (rst_en === 1'h0 && lo < 200) begin
            @(posedge clk_i);
            lo++;
        end
        check(lo >= MUTE_C + FILT_C + 1 && lo < 200, 1'h1);
        repeat (20) @(posedge clk_i);
        check(flt_n, 1'h1);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[2:0], 3'h6);
        wr(STATUS_OFS, 32'h1 << ST_FAULT_SEEN);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[ST_FAULT_SEEN], 1'h0);
        repeat (40) @(posedge clk_i);
        count(80, p, g);
        check(p, 40);
        check(g, 40);
    endtask : t_fault
    task automatic t_auto();
        int i, m, p, g;
        wr(CTRL_OFS, ENR | AUTO);
        repeat (40) @(posedge clk_i);
        m = 0;
        for (i = 0; i < 80; i++) begin
            @(posedge clk_i);
            m += int'(rst_en !== pos);
        end
        check(m, 0);
        oc <= 1'h1;
        @(posedge clk_i);
        oc <= 1'h0;
        repeat (120) @(posedge clk_i);
        check(flt_n, 1'h1);
        wr(CTRL_OFS, ENR | AUTO | NEGM);
        repeat (40) @(posedge clk_i);
        m = 0;
        for (i = 0; i < 80; i++) begin
            @(posedge clk_i);
            m += int'(rst_en !== !neg || pos !== 1'h1);
        end
        check(m, 0);
        wr(CTRL_OFS, ENR | NEGM);
        repeat (40) @(posedge clk_i);
        count(80, p, g);
        check(p, 80);
        check(g, 40);
    endtask : t_auto
    task automatic t_uv();
        logic [31:0] q;
        int p, g;
        wr(CTRL_OFS, ENR);
        uv <= 1'h1;
        repeat (12) @(posedge clk_i);
        count(40, p, g);
        check(p + g, 0);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[ST_READY], 1'h0);
        uv <= 1'h0;
        repeat (12) @(posedge clk_i);
        bus(STATUS_OFS, 1'h0, 32'h0, q); check(q[ST_READY], 1'h1);
    endtask : t_uv
    task automatic t_auto_clear();
        logic [31:0] q;
        wr(CTRL_OFS, ENR | (32'h1 << CTRL_AUTO_CLEAR));
        oc <= 1'h1;
        @(posedge clk_i);
        oc <= 1'h0;
        repeat (16) @(posedge clk_i);
        check(rst_en, 1'h0);
        repeat (100) @(posedge clk_i);
        check(flt_n, 1'h1);
        bus(STATUS_OFS, 1'h0, 32'h0, q);
        check(q[ST_BUSY], 1'h0);
    endtask : t_auto_clear
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_regs();
        t_pwm();
        t_fault();
        t_auto();
        t_uv();
        t_auto_clear();
        end_of_test();
    end
endmodule : testbench
